/* include/qlps_pkg.sv */
// package: constants, types and helpers of the quadrature lo phase select
package qlps_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [7:0] PHASE_CODE_OFFSET = 8'h2d; // per-channel phase
  localparam logic [7:0] REF_SELECT_OFFSET = 8'h18; // reference choice
  localparam logic [3:0] PHASE_CODE_RESET  = 4'h0;  // no rotation
  localparam logic       REF_EXT_RESET     = 1'b0;  // internal reference
  localparam int         PHASE_CODE_LSB    = 0;     // code field [3:0]
  localparam int         PHASE_CODE_W      = 4;     // sixteen steps
  localparam int         REF_EXT_BIT       = 0;     // 1 = external ref

  // ********************************************************************
  // divider states: two-bit johnson count, gray along the cycle
  // ********************************************************************
  typedef enum logic [1:0] {
    DIV_S0 = 2'h0,   // 0 deg, reset state
    DIV_S1 = 2'h1,   // 90 deg
    DIV_S2 = 2'h3,   // 180 deg
    DIV_S3 = 2'h2    // 270 deg
  } qlps_div_state_t;

  // johnson state to quarter-turn index
  function automatic logic [1:0] qlps_to_idx(input logic [1:0] s);
    logic [1:0] r;
    r = 2'h0;
    case (s)
      DIV_S0:  r = 2'h0;
      DIV_S1:  r = 2'h1;
      DIV_S2:  r = 2'h2;
      DIV_S3:  r = 2'h3;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // quarter-turn index back to johnson state
  function automatic logic [1:0] qlps_to_state(input logic [1:0] i);
    logic [1:0] r;
    r = DIV_S0;
    case (i)
      2'h0:    r = DIV_S0;
      2'h1:    r = DIV_S1;
      2'h2:    r = DIV_S2;
      2'h3:    r = DIV_S3;
      default: r = DIV_S0;
    endcase
    return r;
  endfunction

endpackage

/* include/qlps_lo_if.sv */
// interface: divider state shared from the divider to channel rotators
`timescale 1ns/1ns
`default_nettype none
interface qlps_lo_if;
  logic [1:0] div_state;   // current johnson count of the divider
  logic       sync_hold;   // array reset pulse is held

  modport src  (output div_state, output sync_hold);
  modport sink (input  div_state, input  sync_hold);
endinterface
`default_nettype wire

/* core/qlps_chan_rot.sv */
// one channel phase rotator: quarter turns plus fine step weight
`timescale 1ns/1ns
`default_nettype none
module qlps_chan_rot
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // shared divider state
  qlps_lo_if.sink         lo,
  // channel phase code
  input  wire logic [3:0] code,
  // rotated lo and fine weight
  output var  logic       rot_i_q,
  output var  logic       rot_q_q,
  output var  logic [1:0] fine_q
);

  // ********************************************************************
  // rotation
  // ********************************************************************
  logic [1:0] rot_idx;   // advanced quarter-turn index
  logic [1:0] rot_st;    // advanced johnson state

  // upper code bits advance by whole quarter turns; higher code leads
  always_comb
  begin
    rot_idx = 2'(qlps_pkg::qlps_to_idx(lo.div_state) + code[3:2]);
    rot_st  = qlps_pkg::qlps_to_state(rot_idx);
  end

  // registered, one clk behind the divider on every channel alike,
  // so relative phase between channels is untouched
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rot_i_q <= 1'b0;
      rot_q_q <= 1'b0;
      fine_q  <= 2'h0;
    end
    else
    begin
      rot_i_q <= rot_st[1];
      rot_q_q <= rot_st[0];
      fine_q  <= code[1:0];     // 22.5 deg steps for the mixer weights
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  a_rot_quadrant: assert property (
    @(posedge clk) disable iff (!resetn)
    $past(resetn) |-> {rot_i_q, rot_q_q} == qlps_pkg::qlps_to_state(
      2'(qlps_pkg::qlps_to_idx($past(lo.div_state)) + $past(code[3:2]))))
    else $error("rotated lo does not match code quadrant");

  // after the shared pulse every channel lands on its own code quadrant,
  // which is what keeps equal codes of different devices in phase
  a_rot_after_sync: assert property (
    @(posedge clk) disable iff (!resetn)
    lo.sync_hold |-> ##2 {rot_i_q, rot_q_q} ==
      qlps_pkg::qlps_to_state($past(code[3:2])))
    else $error("rotated lo not aligned to code after sync");

endmodule
`default_nettype wire

/* core/qlps_top.sv */
// top: divide-by-four quadrature lo generator with per-channel phase select
// Function
// - divide 4x lo by four for i/q
// - both lo outputs keep 50% duty
// - final lo flops clocked by 4x lo
// - array reset forces divider known state
// - per-channel 4-bit phase code field
// - shift equals code times 22.5 degrees
// - equal codes in phase, +1 leads
// - reference select, internal after reset
// - divider resumes on next edge
// - unsynced dividers sit in four phases
`timescale 1ns/1ns
`default_nettype none
module qlps_top
#(
  parameter int NUM_CH = 8,                 // channels per device
  parameter int CH_W   = $clog2(NUM_CH)     // channel select width
)
(
  // 4x lo clock and reset
  input  wire logic              clk,       // the four-times lo clock
  input  wire logic              resetn,
  // array-wide synchronising pulse, active high
  input  wire logic              array_sync_reset,
  // register port
  input  wire logic              reg_wr_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wr_data,
  input  wire logic [CH_W-1:0]   reg_chan,
  output var  logic [7:0]        reg_rd_data_q,
  // quadrature lo outputs
  output var  logic              lo_i_q,
  output var  logic              lo_q_q,
  // per-channel rotated lo
  output var  logic [NUM_CH-1:0] chan_lo_i_q,
  output var  logic [NUM_CH-1:0] chan_lo_q_q,
  output var  logic [2*NUM_CH-1:0] chan_fine_q,
  // reference choice
  output var  logic              ext_ref_sel_q
);

  // ********************************************************************
  // elaboration checks
  // ********************************************************************
  // the equal-code check compares two channels, and the select is narrow
  if (NUM_CH < 2 || NUM_CH > 16)
  begin : g_bad_ch
    $error("NUM_CH must be 2 to 16");
  end
  if (CH_W < 1 || (1 << CH_W) < NUM_CH)
  begin : g_bad_w
    $error("CH_W too narrow for NUM_CH");
  end

  // ********************************************************************
  // divider
  // ********************************************************************
  qlps_pkg::qlps_div_state_t div_q;   // johnson count, four states
  qlps_pkg::qlps_div_state_t div_d;   // next count
  qlps_lo_if                 lo_bus ();

  // johnson step: each bit high two of four cycles whatever the input
  // duty, which only moves edges and never the count
  always_comb
  begin
    if (array_sync_reset)
      div_d = qlps_pkg::DIV_S0;
    else
    begin
      case (div_q)
        qlps_pkg::DIV_S0: div_d = qlps_pkg::DIV_S1;  // resumes here
        qlps_pkg::DIV_S1: div_d = qlps_pkg::DIV_S2;
        qlps_pkg::DIV_S2: div_d = qlps_pkg::DIV_S3;
        qlps_pkg::DIV_S3: div_d = qlps_pkg::DIV_S0;
        default:          div_d = qlps_pkg::DIV_S0;
      endcase
    end
  end

  // divider count; the shared pulse aligns every device of an array
  always_ff @(posedge clk)
  begin
    if (!resetn)
      div_q <= qlps_pkg::DIV_S0;
    else
      div_q <= div_d;
  end

  // final stage retimed by the 4x lo itself, so gate delay in the
  // next-state logic never reaches the lo edges
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      lo_i_q <= 1'b0;
      lo_q_q <= 1'b0;
    end
    else
    begin
      lo_i_q <= div_d[1];   // 0 deg
      lo_q_q <= div_d[0];   // 90 deg, rises first after reset
    end
  end

  assign lo_bus.div_state = div_q;
  assign lo_bus.sync_hold = array_sync_reset;

  // ********************************************************************
  // registers
  // ********************************************************************
  logic [3:0] phase_code_q [NUM_CH];   // one code per channel

  // phase codes: only the low nibble is stored, upper bits reserved
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int c = 0; c < NUM_CH; c++)
        phase_code_q[c] <= qlps_pkg::PHASE_CODE_RESET;
    end
    else if (reg_wr_en && reg_addr == qlps_pkg::PHASE_CODE_OFFSET)
    begin
      phase_code_q[reg_chan] <= reg_wr_data[qlps_pkg::PHASE_CODE_LSB +:
                                            qlps_pkg::PHASE_CODE_W];
    end
  end

  // reference choice; internal until software asks otherwise
  always_ff @(posedge clk)
  begin
    if (!resetn)
      ext_ref_sel_q <= qlps_pkg::REF_EXT_RESET;
    else if (reg_wr_en && reg_addr == qlps_pkg::REF_SELECT_OFFSET)
      ext_ref_sel_q <= reg_wr_data[qlps_pkg::REF_EXT_BIT];
  end

  // read data, registered; unmapped addresses read zero
  always_ff @(posedge clk)
  begin
    if (!resetn)
      reg_rd_data_q <= 8'h00;
    else if (reg_addr == qlps_pkg::PHASE_CODE_OFFSET)
      reg_rd_data_q <= {4'h0, phase_code_q[reg_chan]};
    else if (reg_addr == qlps_pkg::REF_SELECT_OFFSET)
      reg_rd_data_q <= {7'h00, ext_ref_sel_q};
    else
      reg_rd_data_q <= 8'h00;
  end

  // ********************************************************************
  // channel rotators
  // ********************************************************************
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    qlps_chan_rot u_rot
    (
      .clk     (clk),
      .resetn  (resetn),
      .lo      (lo_bus),
      .code    (phase_code_q[c]),
      .rot_i_q (chan_lo_i_q[c]),
      .rot_q_q (chan_lo_q_q[c]),
      .fine_q  (chan_fine_q[2*c +: 2])
    );
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  logic [2:0] quiet_q;   // cycles since the last sync pulse, saturating

  // helper count for the period and duty checks
  always_ff @(posedge clk)
  begin
    if (!resetn || array_sync_reset)
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h7)
      quiet_q <= quiet_q + 3'h1;
  end

  a_div_period: assert property (
    @(posedge clk) disable iff (!resetn)
    quiet_q == 3'h7 |-> div_q == $past(div_q, 4) && div_q != $past(div_q))
    else $error("divider period is not four cycles");

  a_duty_half: assert property (
    @(posedge clk) disable iff (!resetn)
    quiet_q == 3'h7 |-> $countones({lo_i_q, $past(lo_i_q),
      $past(lo_i_q, 2), $past(lo_i_q, 3)}) == 2 &&
      $countones({lo_q_q, $past(lo_q_q), $past(lo_q_q, 2),
      $past(lo_q_q, 3)}) == 2)
    else $error("lo duty cycle is not half");

  a_lo_reclock: assert property (
    @(posedge clk) disable iff (!resetn)
    $past(resetn) |-> lo_i_q == div_q[1] && lo_q_q == div_q[0])
    else $error("final lo stage not aligned to divider");

  a_sync_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    array_sync_reset |=> div_q == qlps_pkg::DIV_S0 && !lo_i_q && !lo_q_q)
    else $error("sync pulse did not clear divider");

  a_sync_resume: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(array_sync_reset) |=> div_q == qlps_pkg::DIV_S1)
    else $error("divider did not resume on next edge");

  a_q_before_i: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(array_sync_reset) |=> (lo_q_q && !lo_i_q) ##1 (lo_q_q && lo_i_q))
    else $error("quadrature order after sync wrong");

  a_code_write: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_wr_en && reg_addr == qlps_pkg::PHASE_CODE_OFFSET |=>
      phase_code_q[$past(reg_chan)] == $past(reg_wr_data[3:0]))
    else $error("phase code write not stored");

  a_ref_default: assert property (
    @(posedge clk)
    !resetn |=> !ext_ref_sel_q)
    else $error("reference not internal after reset");

  a_equal_codes: assert property (
    @(posedge clk) disable iff (!resetn)
    $past(resetn) && $past(phase_code_q[0]) == $past(phase_code_q[1]) |->
      chan_lo_i_q[0] == chan_lo_i_q[1] && chan_lo_q_q[0] == chan_lo_q_q[1]
      && chan_fine_q[1:0] == chan_fine_q[3:2])
    else $error("equal codes gave unequal channel phase");

endmodule
`default_nettype wire

/* verification/qlps_sync_ctl.sv */
// partner model: array reset controller sending the common sync pulse
`timescale 1ns/1ns
`default_nettype none
module qlps_sync_ctl
(
  // clock from the 4x lo source
  input  wire logic clk,
  // request from the bench, level
  input  wire logic req,
  // common pulse to every device of the array
  output var  logic array_sync_reset
);
  // low until the first request
  initial array_sync_reset = 1'b0;

  // pulse follows the request one edge later; updated on the edge itself,
  // so no race with the bench moving req and every device of the array
  // samples one settled level at the next rising edge
  always @(posedge clk)
  begin
    array_sync_reset <= req;
  end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// testbench: register access, divider sync and channel rotation checks
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ******************************************************************
  // signals
  // ******************************************************************
  logic       clk       = 1'b0;  // 4x lo clock
  logic       resetn    = 1'b0;  // sync reset, active low
  logic       req       = 1'b0;  // sync pulse request
  logic       sync;              // common sync pulse
  logic       reg_wr_en = 1'b0;  // write strobe
  logic [7:0] reg_addr  = 8'h00; // register address
  logic [7:0] reg_wdat  = 8'h00; // write data
  logic [1:0] reg_chan  = 2'h0;  // channel select
  logic [7:0] rdat;              // read data
  logic       lo_i;              // 0 deg lo
  logic       lo_q;              // 90 deg lo
  logic [3:0] ci;                // rotated i per channel
  logic [3:0] cq;                // rotated q per channel
  logic [7:0] cf;                // fine weights
  logic       ext;               // external reference chosen
  int         n_fail       = 0;  // mismatches
  int         total_checks = 0;  // comparisons
  // two passes of codes; upper nibbles must be dropped
  logic [7:0] codes [0:7] = '{8'h00, 8'h01, 8'hf6, 8'h0f,
                              8'h0a, 8'h04, 8'h0c, 8'h0b};

  // 50 MHz clock
  always #10 clk = ~clk;

  qlps_top #(.NUM_CH(4)) i_qlps_top (.clk(clk), .resetn(resetn),
    .array_sync_reset(sync), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wdat), .reg_chan(reg_chan), .reg_rd_data_q(rdat),
    .lo_i_q(lo_i), .lo_q_q(lo_q), .chan_lo_i_q(ci), .chan_lo_q_q(cq),
    .chan_fine_q(cf), .ext_ref_sel_q(ext));

  qlps_sync_ctl i_qlps_sync_ctl (.clk(clk), .req(req),
    .array_sync_reset(sync));

  // ******************************************************************
  // tasks
  // ******************************************************************
  // inputs always move 2 ns after the rising edge
  task automatic step;
    @(posedge clk);
    #2;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobe stays high for back-to-back writes; idle drops it
  task automatic wr(input logic [7:0] a, input logic [1:0] c,
                    input logic [7:0] d);
    reg_addr  = a;
    reg_chan  = c;
    reg_wdat  = d;
    reg_wr_en = 1'b1;
    step();
  endtask

  task automatic idle;
    reg_wr_en = 1'b0;
    step();
  endtask

  // two edges so the registered read surely holds the new address
  task automatic rd(input logic [7:0] a, input logic [1:0] c,
                    input logic [7:0] exp);
    reg_addr = a;
    reg_chan = c;
    step();
    step();
    chk_reg(rdat, exp);
  endtask

  // quarter-turn index to (i,q) levels
  function automatic logic [1:0] iq(input int k);
    logic [1:0] x;
    x = k[1:0];
    return {x[1], x[1] ^ x[0]};
  endfunction

  // sync pulse, then eight edges of lo and channel outputs
  task automatic run_lo(input int p);
    logic [15:0] e;
    int          r;
    req = 1'b1;
    step();
    req = 1'b0;
    step();
    chk_out({14'h0, lo_i, lo_q}, 16'h0000);
    for (int k = 1; k <= 8; k++)
    begin
      step();
      chk_out({14'h0, lo_i, lo_q}, {14'h0, iq(k)});
      e = 16'h0000;
      for (int c = 0; c < 4; c++)
      begin
        r = int'(codes[p*4+c][3:2]);
        {e[12+c], e[8+c]} = iq(k - 1 + r);
        e[2*c+:2] = codes[p*4+c][1:0];
      end
      chk_out({ci, cq, cf}, e);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ******************************************************************
  // sequence
  // ******************************************************************
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial
  begin
    repeat (8) step();
    resetn = 1'b1;
    chk_out({15'h0, ext}, 16'h0000);
    rd(8'h18, 2'h0, 8'h00);
    for (int c = 0; c < 4; c++)
      rd(8'h2d, c[1:0], 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      for (int c = 0; c < 4; c++)
        wr(8'h2d, c[1:0], codes[p*4+c]);
      idle();
      for (int c = 0; c < 4; c++)
        rd(8'h2d, c[1:0], codes[p*4+c] & 8'h0f);
      run_lo(p);
    end
    wr(8'h2e, 2'h1, 8'hff);
    wr(8'h18, 2'h0, 8'hff);
    idle();
    rd(8'h2e, 2'h1, 8'h00);
    rd(8'h2d, 2'h1, 8'h04);
    rd(8'h18, 2'h0, 8'h01);
    chk_out({15'h0, ext}, 16'h0001);
    resetn = 1'b0;
    repeat (8) step();
    resetn = 1'b1;
    chk_out({15'h0, ext}, 16'h0000);
    rd(8'h2d, 2'h3, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
